//--- verilog/srp_pkg.sv
// Package of constants and command codes for the status reporting block
package srp_pkg;
	// Questionable sync register field positions
	localparam int SRP_Q_BURST = 0;
	localparam int SRP_Q_SYNC = 1;
	localparam int SRP_Q_NOCARR = 2;
	localparam int SRP_Q_OVLD = 3;
	localparam logic [15:0] SRP_Q_USED = 16'h000f;
	// Status byte bit positions
	localparam int SRP_STB_ERRQ = 2;
	localparam int SRP_STB_QUES = 3;
	localparam int SRP_STB_MAV = 4;
	localparam int SRP_STB_ESB = 5;
	localparam int SRP_STB_MSS = 6;
	localparam int SRP_STB_OPER = 7;
	localparam logic [7:0] SRP_STB_NO_MSS = 8'hbf;
	// Event status bit for operation complete
	localparam int SRP_ESR_OPC = 0;
	// Reset and preset values
	localparam logic [15:0] SRP_PTR_PRESET = 16'hffff;
	localparam logic [15:0] SRP_NTR_PRESET = 16'h0000;
	localparam logic [15:0] SRP_EN_PRESET = 16'h0000;
	localparam logic [7:0] SRP_MASK_RESET = 8'h00;
	localparam logic [15:0] SRP_NO_ERROR = 16'h0000;
	// Error queue shape
	localparam int SRP_ERRQ_DEPTH = 4;
	localparam int SRP_ERRQ_AW = 2;
	// Parallel poll configuration field positions in cmd_data
	localparam int SRP_PPC_INV = 3;
	localparam int SRP_PPC_EN = 4;

	typedef enum logic [3:0] {
		SRP_CMD_SYNC_COND,
		SRP_CMD_SYNC_EVENT,
		SRP_CMD_SYNC_ENABLE,
		SRP_CMD_SYNC_PTR,
		SRP_CMD_SYNC_NTR,
		SRP_CMD_STB,
		SRP_CMD_ESR,
		SRP_CMD_SRE,
		SRP_CMD_ESE,
		SRP_CMD_PPE,
		SRP_CMD_PPC,
		SRP_CMD_IST,
		SRP_CMD_ERR,
		SRP_CMD_CLS,
		SRP_CMD_PRESET
	} srp_cmd_e;
endpackage

//--- verilog/srp_status.sv
// Status reporting core: questionable sync register, SRQ and polls
`timescale 1ns/100ps
module srp_status
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic burst_missing,
	input wire logic burst_found,
	input wire logic sync_missing,
	input wire logic sync_found,
	input wire logic video_trigger_option,
	input wire logic free_run_mode,
	input wire logic trig_no_data,
	input wire logic premeas_start,
	input wire logic carrier_low,
	input wire logic carrier_high,
	input wire logic [7:0] esr_set,
	input wire logic ques_other_sum,
	input wire logic oper_sum,
	input wire logic msg_avail,
	input wire logic err_push,
	input wire logic [15:0] err_code,
	input wire logic cmd_valid,
	input wire srp_pkg::srp_cmd_e cmd_code,
	input wire logic cmd_write,
	input wire logic [15:0] cmd_data,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic srq_req,
	input wire logic spoll_req,
	output logic [7:0] spoll_data,
	input wire logic ppoll_req,
	input wire logic [7:0] dio_in,
	output logic [7:0] dio_out,
	output logic [7:0] dio_oe_n
);
	import srp_pkg::*;

	logic [15:0] cond_reg, cond_next, event_reg, event_next;
	logic [15:0] en_reg, en_next, ptr_reg, ptr_next, ntr_reg, ntr_next;
	logic [15:0] rsp_data_reg, rsp_data_next, cond_live, ev_sets;
	logic [7:0] esr_reg, esr_next, sre_reg, sre_next, ese_reg, ese_next;
	logic [7:0] ppe_reg, ppe_next, spoll_reg, spoll_next, stb;
	logic [7:0] dio_out_reg, dio_out_next, dio_oe_n_reg, dio_oe_n_next;
	logic [2:0] ppc_line_reg, ppc_line_next;
	logic ppc_inv_reg, ppc_inv_next, ppc_en_reg, ppc_en_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic [SRP_ERRQ_AW-1:0] rd_ptr_reg, rd_ptr_next;
	logic [SRP_ERRQ_AW-1:0] wr_ptr_reg, wr_ptr_next;
	logic [SRP_ERRQ_AW:0] cnt_reg, cnt_next;
	logic [15:0] errq_mem [SRP_ERRQ_DEPTH];
	logic ist_bit, pp_bit, rd, wr, err_pop, err_wr;
	// Decoded command test, used in two places below
	function automatic logic cmd_is(input srp_cmd_e c, input srp_cmd_e k);
		cmd_is = (c == k);
	endfunction

	// Live condition: two or three measurement events update each bit
	always_comb
	begin
		cond_live = cond_reg;
		if (burst_missing)
			cond_live[SRP_Q_BURST] = 1'b1;
		else if (burst_found)
			cond_live[SRP_Q_BURST] = 1'b0;
		if (sync_missing)
			cond_live[SRP_Q_SYNC] = 1'b1;
		else if (video_trigger_option && free_run_mode && trig_no_data)
			cond_live[SRP_Q_SYNC] = 1'b1;
		else if (sync_found)
			cond_live[SRP_Q_SYNC] = 1'b0;
		// Set wins, so a low result in the start cycle is kept
		if (carrier_low)
			cond_live[SRP_Q_NOCARR] = 1'b1;
		else if (premeas_start)
			cond_live[SRP_Q_NOCARR] = 1'b0;
		if (carrier_high)
			cond_live[SRP_Q_OVLD] = 1'b1;
		else if (premeas_start)
			cond_live[SRP_Q_OVLD] = 1'b0;
		cond_live = cond_live & SRP_Q_USED;
	end

	// Filtered transitions that latch into the event part
	assign ev_sets = ((cond_live & ~cond_reg & ptr_reg)
		| (~cond_live & cond_reg & ntr_reg)) & SRP_Q_USED;
	// Status byte; ESB, MSS and the event part of QUES pass their enable masks, ques_other_sum and oper_sum enter unmasked
	always_comb
	begin
		stb = 8'h00;
		stb[SRP_STB_ERRQ] = (cnt_reg != '0);
		stb[SRP_STB_QUES] = (|(event_reg & en_reg)) | ques_other_sum;
		stb[SRP_STB_MAV] = msg_avail;
		stb[SRP_STB_ESB] = |(esr_reg & ese_reg);
		stb[SRP_STB_OPER] = oper_sum;
		stb[SRP_STB_MSS] = |(stb & sre_reg & SRP_STB_NO_MSS);
	end

	// Request line is a level; the only activity raised unasked
	assign srq_req = stb[SRP_STB_MSS];
	assign ist_bit = |(ppe_reg & stb);
	assign pp_bit = ist_bit ^ ppc_inv_reg;

	assign wr = cmd_valid && cmd_write;
	assign rd = cmd_valid && !cmd_write;
	assign err_pop = rd && cmd_is(cmd_code, SRP_CMD_ERR) && (cnt_reg != '0);
	// A full queue drops new entries rather than overwrite old ones
	assign err_wr = err_push && (cnt_reg != (SRP_ERRQ_AW+1)'(SRP_ERRQ_DEPTH));

	// Next state for all registers but the poll outputs, and the command answer
	always_comb
	begin
		cond_next = cond_live;
		event_next = event_reg;
		en_next = en_reg;
		ptr_next = ptr_reg;
		ntr_next = ntr_reg;
		esr_next = esr_reg;
		sre_next = sre_reg;
		ese_next = ese_reg;
		ppe_next = ppe_reg;
		ppc_line_next = ppc_line_reg;
		ppc_inv_next = ppc_inv_reg;
		ppc_en_next = ppc_en_reg;
		rsp_valid_next = rd;
		rsp_data_next = rsp_data_reg;
		rd_ptr_next = rd_ptr_reg;
		wr_ptr_next = wr_ptr_reg;
		cnt_next = cnt_reg;
		if (rd)
		begin
			unique case (cmd_code)
				SRP_CMD_SYNC_COND: rsp_data_next = cond_reg;
				SRP_CMD_SYNC_EVENT:
				begin
					rsp_data_next = event_reg;
					event_next = 16'h0000;
				end
				SRP_CMD_SYNC_ENABLE: rsp_data_next = en_reg;
				SRP_CMD_SYNC_PTR: rsp_data_next = ptr_reg;
				SRP_CMD_SYNC_NTR: rsp_data_next = ntr_reg;
				SRP_CMD_STB: rsp_data_next = {8'h00, stb};
				SRP_CMD_ESR:
				begin
					rsp_data_next = {8'h00, esr_reg};
					esr_next = 8'h00;
				end
				SRP_CMD_SRE: rsp_data_next = {8'h00, sre_reg};
				SRP_CMD_ESE: rsp_data_next = {8'h00, ese_reg};
				SRP_CMD_PPE: rsp_data_next = {8'h00, ppe_reg};
				SRP_CMD_IST: rsp_data_next = {15'h0000, ist_bit};
				SRP_CMD_ERR: rsp_data_next = err_pop ? errq_mem[rd_ptr_reg]
					: SRP_NO_ERROR;
				default: rsp_data_next = 16'h0000;
			endcase
		end
		else if (wr)
		begin
			unique case (cmd_code)
				SRP_CMD_SYNC_ENABLE: en_next = cmd_data & SRP_Q_USED;
				SRP_CMD_SYNC_PTR: ptr_next = cmd_data;
				SRP_CMD_SYNC_NTR: ntr_next = cmd_data;
				SRP_CMD_SRE: sre_next = cmd_data[7:0] & SRP_STB_NO_MSS;
				SRP_CMD_ESE: ese_next = cmd_data[7:0];
				SRP_CMD_PPE: ppe_next = cmd_data[7:0];
				SRP_CMD_PPC:
				begin
					ppc_line_next = cmd_data[2:0];
					ppc_inv_next = cmd_data[SRP_PPC_INV];
					ppc_en_next = cmd_data[SRP_PPC_EN];
				end
				SRP_CMD_CLS:
				begin
					esr_next = 8'h00;
					event_next = 16'h0000;
					cnt_next = '0;
					rd_ptr_next = '0;
					wr_ptr_next = '0;
				end
				SRP_CMD_PRESET:
				begin
					en_next = SRP_EN_PRESET;
					ptr_next = SRP_PTR_PRESET;
					ntr_next = SRP_NTR_PRESET;
				end
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		event_next = event_next | ev_sets;
		esr_next = esr_next | esr_set;
		if (!(wr && cmd_is(cmd_code, SRP_CMD_CLS)))
		begin
			if (err_pop)
				rd_ptr_next = rd_ptr_reg + 1'b1;
			if (err_wr)
				wr_ptr_next = wr_ptr_reg + 1'b1;
			cnt_next = cnt_reg + (SRP_ERRQ_AW+1)'(err_wr)
				- (SRP_ERRQ_AW+1)'(err_pop);
		end
	end

	// Poll outputs: serial byte on request, one line on parallel poll
	always_comb
	begin
		spoll_next = spoll_reg;
		if (spoll_req)
			spoll_next = stb;
		dio_out_next = 8'h00;
		dio_oe_n_next = 8'hff;
		if (ppoll_req && ppc_en_reg)
		begin
			dio_out_next[ppc_line_reg] = pp_bit;
			dio_oe_n_next[ppc_line_reg] = 1'b0;
		end
	end

	// Error queue storage; writes only, no reset needed
	always_ff @(posedge sys_clk)
	begin
		if (err_wr)
			errq_mem[wr_ptr_reg] <= err_code;
	end

	// Register all state; power-on acts as clear status and preset
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cond_reg <= 16'h0000;
			event_reg <= 16'h0000;
			en_reg <= SRP_EN_PRESET;
			ptr_reg <= SRP_PTR_PRESET;
			ntr_reg <= SRP_NTR_PRESET;
			esr_reg <= 8'h00;
			sre_reg <= SRP_MASK_RESET;
			ese_reg <= SRP_MASK_RESET;
			ppe_reg <= SRP_MASK_RESET;
			ppc_line_reg <= 3'h0;
			ppc_inv_reg <= 1'b0;
			ppc_en_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= 16'h0000;
			spoll_reg <= 8'h00;
			dio_out_reg <= 8'h00;
			dio_oe_n_reg <= 8'hff;
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			cond_reg <= cond_next;
			event_reg <= event_next;
			en_reg <= en_next;
			ptr_reg <= ptr_next;
			ntr_reg <= ntr_next;
			esr_reg <= esr_next;
			sre_reg <= sre_next;
			ese_reg <= ese_next;
			ppe_reg <= ppe_next;
			ppc_line_reg <= ppc_line_next;
			ppc_inv_reg <= ppc_inv_next;
			ppc_en_reg <= ppc_en_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg <= rsp_data_next;
			spoll_reg <= spoll_next;
			dio_out_reg <= dio_out_next;
			dio_oe_n_reg <= dio_oe_n_next;
			rd_ptr_reg <= rd_ptr_next;
			wr_ptr_reg <= wr_ptr_next;
			cnt_reg <= cnt_next;
		end
	end

	assign rsp_valid = rsp_valid_reg;
	assign rsp_data = rsp_data_reg;
	assign spoll_data = spoll_reg;
	assign dio_out = dio_out_reg;
	assign dio_oe_n = dio_oe_n_reg;
	// Checks on the behaviour above
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_burst_set: assert property (burst_missing |=> cond_reg[SRP_Q_BURST])
		else $error("burst bit not set");
	a_burst_clear: assert property (burst_found && !burst_missing
		|=> !cond_reg[SRP_Q_BURST])
		else $error("burst bit not cleared");
	a_sync_found: assert property (sync_found && !sync_missing
		&& !(video_trigger_option && free_run_mode && trig_no_data)
		|=> !cond_reg[SRP_Q_SYNC])
		else $error("sync bit not cleared");
	a_trig_nodata: assert property (video_trigger_option && free_run_mode
		&& trig_no_data |=> cond_reg[SRP_Q_SYNC])
		else $error("trigger no data did not set sync bit");
	a_premeas_low: assert property (premeas_start && !carrier_low
		|=> !cond_reg[SRP_Q_NOCARR])
		else $error("no carrier bit not cleared at start");
	a_carrier_high: assert property (carrier_high
		|=> cond_reg[SRP_Q_OVLD] ##1 $stable(cond_reg[SRP_Q_OVLD])
		|| $past(premeas_start, 1) || $past(carrier_high, 1))
		else $error("overload bit not held");
	a_unused_zero: assert property ((cond_reg & ~SRP_Q_USED) == 16'h0000
		&& (event_reg & ~SRP_Q_USED) == 16'h0000)
		else $error("unused questionable bits set");
	a_opc_srq: assert property (esr_reg[SRP_ESR_OPC] && ese_reg[SRP_ESR_OPC]
		&& sre_reg[SRP_STB_ESB] |-> srq_req)
		else $error("operation complete gave no request");
	a_srq_cause: assert property ($rose(srq_req) |-> |(stb & sre_reg))
		else $error("request without enabled cause");
	a_spoll_byte: assert property (spoll_req |=> spoll_data == $past(stb))
		else $error("serial poll byte wrong");
	a_ppoll_one: assert property (ppoll_req && ppc_en_reg
		|=> $countones(~dio_oe_n) == 1
		&& dio_out[$past(ppc_line_reg)] == $past(pp_bit))
		else $error("parallel poll not one line");
	a_ist_value: assert property (rd && cmd_code == SRP_CMD_IST
		|=> rsp_valid && rsp_data == {15'h0000, $past(ist_bit)})
		else $error("individual status answer wrong");
	a_event_read: assert property (rd && cmd_code == SRP_CMD_SYNC_EVENT
		|=> rsp_data == $past(event_reg)
		&& event_reg == $past(ev_sets))
		else $error("event read or clear wrong");
	a_cls_clear: assert property (wr && cmd_code == SRP_CMD_CLS && !err_push
		|=> cnt_reg == '0 ##1 !stb[SRP_STB_ERRQ] || $past(err_push))
		else $error("clear status left error queue");
	a_preset_vals: assert property (wr && cmd_code == SRP_CMD_PRESET
		|=> ptr_reg == SRP_PTR_PRESET && ntr_reg == SRP_NTR_PRESET
		&& en_reg == SRP_EN_PRESET)
		else $error("preset values wrong");
	a_errq_empty: assert property (rd && cmd_code == SRP_CMD_ERR
		&& cnt_reg == '0 |=> rsp_data == SRP_NO_ERROR)
		else $error("empty error query not zero");
	c_srq_raised: cover property ($rose(srq_req));
	c_ppoll_drive: cover property (ppoll_req && ppc_en_reg ##1 !(&dio_oe_n));
	c_err_pop: cover property (err_pop);
	c_event_latch: cover property (|ev_sets ##[1:20] rd
		&& cmd_code == SRP_CMD_SYNC_EVENT);
endmodule // srp_status

//--- testbench/srp_ctrl_model.sv
// Controller program model: command strobes, serial and parallel polls
`timescale 1ns/100ps
module srp_ctrl_model
(
	input wire logic sys_clk,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic [7:0] dio_out,
	input wire logic [7:0] dio_oe_n,
	output logic cmd_valid,
	output srp_pkg::srp_cmd_e cmd_code,
	output logic cmd_write,
	output logic [15:0] cmd_data,
	output logic spoll_req,
	output logic ppoll_req,
	output logic [7:0] dio_in,
	output logic timed_out
);
	import srp_pkg::*;

	// Released poll lines float up to the pull-up level
	assign dio_in = dio_oe_n | dio_out;

	// Idle bus at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = SRP_CMD_STB;
		cmd_write = 1'b0;
		cmd_data = 16'h0000;
		spoll_req = 1'b0;
		ppoll_req = 1'b0;
		timed_out = 1'b0;
	end

	// One strobe cycle; taken at the edge after it rises
	task automatic issue(input srp_cmd_e c, input logic w,
		input logic [15:0] d);
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_write = w;
		cmd_data = d;
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b0;
	endtask

	task automatic wr(input srp_cmd_e c, input logic [15:0] d);
		issue(c, 1'b1, d);
	endtask

	// Bounded wait for the answer pulse
	task automatic rd(input srp_cmd_e c, output logic [15:0] q);
		int n;
		issue(c, 1'b0, 16'h0000);
		n = 0;
		while (rsp_valid !== 1'b1 && n < 4)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (rsp_valid !== 1'b1)
			timed_out = 1'b1;
		q = rsp_data;
	endtask

	// Recommended setting: every SRE and ESE bit to one
	task automatic fill_enables();
		wr(SRP_CMD_SRE, 16'h00ff);
		wr(SRP_CMD_ESE, 16'h00ff);
	endtask

	// Allot a data line and sense before any poll
	task automatic ppconf(input logic [2:0] line, input logic inv);
		wr(SRP_CMD_PPC, {11'h0, 1'b1, inv, line});
	endtask

	// Same mask for both so the poll finds the requester
	task automatic locate(input logic [7:0] v);
		wr(SRP_CMD_SRE, {8'h00, v});
		wr(SRP_CMD_PPE, {8'h00, v});
	endtask

	task automatic spoll();
		@(posedge sys_clk);
		#1;
		spoll_req = 1'b1;
		@(posedge sys_clk);
		#1;
		spoll_req = 1'b0;
	endtask

	// Lines sampled while the poll is still held
	task automatic ppoll(output logic [7:0] lines, output logic [7:0] oe);
		@(posedge sys_clk);
		#1;
		ppoll_req = 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		#1;
		lines = dio_in;
		oe = dio_oe_n;
		ppoll_req = 1'b0;
	endtask
endmodule // srp_ctrl_model

//--- testbench/testbench.sv
// Self-checking bench for the status reporting block
`timescale 1ns/100ps
module testbench;
	import srp_pkg::*;
	logic sys_clk;
	logic resetn;
	logic [8:0] m;
	logic [7:0] esr;
	logic [2:0] lv;
	logic vopt;
	logic frun;
	logic [15:0] ecode;
	logic [15:0] q;
	logic [7:0] pl;
	logic [7:0] po;
	logic [7:0] sb;
	logic cmd_valid, cmd_write, spoll_req, ppoll_req, rsp_valid, srq_req, tmo;
	srp_cmd_e cmd_code;
	logic [15:0] cmd_data, rsp_data;
	logic [7:0] spoll_data, dio_in, dio_out, dio_oe_n;
	int mismatches;
	int n_checks;

	srp_status u_dut (.sys_clk(sys_clk), .resetn(resetn),
		.burst_missing(m[0]), .burst_found(m[1]), .sync_missing(m[2]),
		.sync_found(m[3]), .video_trigger_option(vopt),
		.free_run_mode(frun), .trig_no_data(m[4]), .premeas_start(m[5]),
		.carrier_low(m[6]), .carrier_high(m[7]), .esr_set(esr),
		.ques_other_sum(lv[0]), .msg_avail(lv[1]), .oper_sum(lv[2]),
		.err_push(m[8]), .err_code(ecode), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .srq_req(srq_req),
		.spoll_req(spoll_req), .spoll_data(spoll_data),
		.ppoll_req(ppoll_req), .dio_in(dio_in), .dio_out(dio_out),
		.dio_oe_n(dio_oe_n));

	srp_ctrl_model u_ctrl (.sys_clk(sys_clk), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .dio_out(dio_out), .dio_oe_n(dio_oe_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
		.cmd_data(cmd_data), .spoll_req(spoll_req), .ppoll_req(ppoll_req),
		.dio_in(dio_in), .timed_out(tmo));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input srp_cmd_e c, input logic [15:0] exp);
		u_ctrl.rd(c, q);
		chk(q, exp);
		if (tmo !== 1'b0)
			give_verdict();
	endtask

	// One-cycle measurement and event pulses
	task automatic pulse(input logic [8:0] p, input logic [7:0] e);
		@(posedge sys_clk);
		#1;
		m = p;
		esr = e;
		@(posedge sys_clk);
		#1;
		m = 9'h000;
		esr = 8'h00;
	endtask

	task automatic give_verdict();
		if (tmo !== 1'b0)
			mismatches++;
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		give_verdict();
	end

	initial
	begin
		mismatches = 0;
		n_checks = 0;
		resetn = 1'b0;
		m = 9'h000;
		esr = 8'h00;
		lv = 3'b000;
		vopt = 1'b0;
		frun = 1'b0;
		ecode = 16'h0000;
		repeat (5) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		chk({8'h00, dio_oe_n}, 16'h00ff);
		chk({15'h0, srq_req}, 16'h0000);
		rdchk(SRP_CMD_STB, 16'h0000);
		// Condition bits set and cleared by their sources
		pulse(9'h001, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0001);
		rdchk(SRP_CMD_SYNC_EVENT, 16'h0001);
		rdchk(SRP_CMD_SYNC_EVENT, 16'h0000);
		pulse(9'h002, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0000);
		pulse(9'h004, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0002);
		pulse(9'h008, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0000);
		vopt = 1'b1;
		pulse(9'h010, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0000);
		frun = 1'b1;
		pulse(9'h010, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0002);
		pulse(9'h0c8, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h000c);
		pulse(9'h020, 8'h00);
		rdchk(SRP_CMD_SYNC_COND, 16'h0000);
		rdchk(SRP_CMD_SYNC_EVENT, 16'h000e);
		// Summary through the enable part, then clear status
		u_ctrl.wr(SRP_CMD_SYNC_ENABLE, 16'h0001);
		pulse(9'h001, 8'h00);
		rdchk(SRP_CMD_STB, 16'h0008);
		u_ctrl.wr(SRP_CMD_SRE, 16'h0008);
		chk({15'h0, srq_req}, 16'h0001);
		u_ctrl.spoll();
		chk({8'h00, spoll_data}, 16'h0048);
		u_ctrl.wr(SRP_CMD_CLS, 16'h0000);
		rdchk(SRP_CMD_STB, 16'h0000);
		rdchk(SRP_CMD_SYNC_EVENT, 16'h0000);
		// Each level summary against its own enable bit
		for (int i = 0; i < 3; i++)
		begin
			sb = (i == 0) ? 8'h08 : ((i == 1) ? 8'h10 : 8'h80);
			lv = 3'b001 << i;
			u_ctrl.wr(SRP_CMD_SRE, {8'h00, 8'h98 ^ sb});
			chk({15'h0, srq_req}, 16'h0000);
			u_ctrl.wr(SRP_CMD_SRE, {8'h00, sb});
			chk({15'h0, srq_req}, 16'h0001);
		end
		lv = 3'b000;
		// Operation complete routed to a service request
		u_ctrl.wr(SRP_CMD_ESE, 16'h0001);
		u_ctrl.wr(SRP_CMD_SRE, 16'h0020);
		pulse(9'h000, 8'h02);
		chk({15'h0, srq_req}, 16'h0000);
		rdchk(SRP_CMD_ESR, 16'h0002);
		pulse(9'h000, 8'h01);
		chk({15'h0, srq_req}, 16'h0001);
		rdchk(SRP_CMD_STB, 16'h0060);
		u_ctrl.spoll();
		chk({8'h00, spoll_data}, 16'h0060);
		rdchk(SRP_CMD_ESR, 16'h0001);
		chk({15'h0, srq_req}, 16'h0000);
		// Parallel poll on line 3, plain and inverted, bit 6 included
		lv = 3'b001;
		u_ctrl.wr(SRP_CMD_PPE, 16'h0008);
		u_ctrl.ppconf(3'h3, 1'b0);
		u_ctrl.ppoll(pl, po);
		chk({po, pl}, 16'hf7ff);
		rdchk(SRP_CMD_IST, 16'h0001);
		u_ctrl.wr(SRP_CMD_PPE, 16'h0040);
		u_ctrl.ppoll(pl, po);
		chk({po, pl}, 16'hf7f7);
		rdchk(SRP_CMD_IST, 16'h0000);
		u_ctrl.locate(8'h08);
		u_ctrl.wr(SRP_CMD_PPE, 16'h0040);
		u_ctrl.ppoll(pl, po);
		chk({po, pl}, 16'hf7ff);
		u_ctrl.ppconf(3'h3, 1'b1);
		u_ctrl.ppoll(pl, po);
		chk({po, pl}, 16'hf7f7);
		u_ctrl.wr(SRP_CMD_PPC, 16'h0003);
		u_ctrl.ppoll(pl, po);
		chk({po, pl}, 16'hffff);
		lv = 3'b000;
		// Error queue pops its one entry, then reports no error
		ecode = 16'h1234;
		pulse(9'h100, 8'h00);
		rdchk(SRP_CMD_STB, 16'h0004);
		rdchk(SRP_CMD_ERR, 16'h1234);
		rdchk(SRP_CMD_ERR, 16'h0000);
		// Falling edge latched through the negative filter, then preset
		u_ctrl.wr(SRP_CMD_SYNC_PTR, 16'h0000);
		u_ctrl.wr(SRP_CMD_SYNC_NTR, 16'h0001);
		pulse(9'h002, 8'h00);
		rdchk(SRP_CMD_SYNC_EVENT, 16'h0001);
		pulse(9'h001, 8'h00);
		rdchk(SRP_CMD_SYNC_EVENT, 16'h0000);
		u_ctrl.wr(SRP_CMD_PRESET, 16'h0000);
		rdchk(SRP_CMD_SYNC_ENABLE, 16'h0000);
		rdchk(SRP_CMD_SYNC_PTR, 16'hffff);
		rdchk(SRP_CMD_SYNC_NTR, 16'h0000);
		u_ctrl.wr(SRP_CMD_SYNC_ENABLE, 16'hffff);
		rdchk(SRP_CMD_SYNC_ENABLE, 16'h000f);
		u_ctrl.fill_enables();
		rdchk(SRP_CMD_SRE, 16'h00bf);
		rdchk(SRP_CMD_ESE, 16'h00ff);
		rdchk(SRP_CMD_PPE, 16'h0040);
		pulse(9'h000, 8'h04);
		chk({15'h0, srq_req}, 16'h0001);
		// Power-on clear again in mid-run, with an error queued
		pulse(9'h100, 8'h00);
		u_ctrl.wr(SRP_CMD_SYNC_PTR, 16'h0000);
		resetn = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		chk({15'h0, srq_req}, 16'h0000);
		rdchk(SRP_CMD_STB, 16'h0000);
		rdchk(SRP_CMD_ERR, 16'h0000);
		rdchk(SRP_CMD_SRE, 16'h0000);
		rdchk(SRP_CMD_PPE, 16'h0000);
		rdchk(SRP_CMD_SYNC_PTR, 16'hffff);
		give_verdict();
	end
endmodule // testbench
